// ### core/pfp_port.sv
// parallel flash programming port: handshake, command decode, page
// load buffer flush, lock bits
// assumes a flash macro on mclk answering each request with fl_ack
//
// Notes on behaviour
// - handshake starts only while ready is high
// - strobe low captures select field and data
// - ready drops after capture; programmer then releases
// - ready rises after operation and strobe high
// - output enable low: drive word, then flag low
// - output enable high: release bus, raise flag
// - ready rises only after strobe seen high
// - new command completes the pending one
// - read: command, address words, chained reads
// - address words may be rewritten mid-sequence
// - load buffer flushed on page change, command
// - page write: command, address, chained words
// - locking write sets region lock after programming
// - erase variant erases page before programming
// - erase-lock variant erases, programs, then locks
// - full erase aborted when any region locked
// - lock set mask locks matching regions
// - lock clear mask unlocks matching regions
// - lock query returns locked-region mask
// - select field routes captured data
// - command codes decode as listed
// - ready low busy; flag shows bus direction
`timescale 1ns/1ns
`include "pfp_params.svh"
module pfp_port #(
    parameter int PAGE_BITS = 8,
    parameter int REGION_PAGE_BITS = 4,
    parameter int NLOCK = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // programmer pins
    input wire logic command_strobe_n_pin,
    input wire logic read_output_enable_n_pin,
    input wire logic [3:0] register_select_field,
    input wire logic [15:0] bidir_data_bus_in,
    output logic [15:0] bidir_data_bus_out,
    output logic bidir_data_bus_oe,
    output logic device_ready_pin,
    output logic data_drive_flag_n_pin,
    // flash macro
    output logic fl_req,
    output logic [1:0] fl_op,
    output logic [31:0] fl_addr,
    output logic [15:0] fl_wdata,
    input wire logic fl_ack,
    input wire logic [15:0] fl_rdata,
    // status
    output logic [NLOCK-1:0] lock_bits
);
    localparam int PW = 32 - PAGE_BITS;
    localparam int LW = $clog2(NLOCK);

    pfp_pkg::pfp_state_t st_r;
    pfp_pkg::pfp_state_t ret_r;
    logic command_strobe_n;
    logic read_output_enable_n;
    logic [3:0] sel_s;
    logic [15:0] data_s;
    logic [3:0] sel_r;
    logic [15:0] data_r;
    logic [15:0] cmd_r;
    logic [31:0] addr_r;
    logic [PW-1:0] buf_page_r;
    logic [(1<<PAGE_BITS)-1:0] valid_r;
    logic [PAGE_BITS-1:0] idx_r;
    logic [15:0] rword_r;
    logic [15:0] buf_rdata;
    logic [LW-1:0] region;
    logic is_wr_cmd, is_lock_var, is_erase_var, dirty, need_flush;
    logic ex, ex_data, buf_we, rd_go, ea_go, pg_erase, idx_last;

    // pins cross into mclk before anything reads them
    pfp_sync #(.W(22)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .pin_in({command_strobe_n_pin, read_output_enable_n_pin,
                 register_select_field, bidir_data_bus_in}),
        .sync_out({command_strobe_n, read_output_enable_n, sel_s, data_s})
    );

    pfp_page_buf #(.AW(PAGE_BITS), .DW(16)) u_buf (
        .mclk(mclk),
        .we(buf_we),
        .waddr(addr_r[PAGE_BITS-1:0]),
        .wdata(data_r),
        .raddr(idx_r),
        .rdata_r(buf_rdata)
    );

    // decode of the latched command
    always_comb begin
        is_wr_cmd = (cmd_r == `PFP_CMD_WP) || (cmd_r == `PFP_CMD_WPL) ||
                    (cmd_r == `PFP_CMD_EWP) || (cmd_r == `PFP_CMD_ERASE_WRITE_LOCK_CMD);
        is_lock_var = (cmd_r == `PFP_CMD_WPL) ||
                      (cmd_r == `PFP_CMD_ERASE_WRITE_LOCK_CMD);
        is_erase_var = (cmd_r == `PFP_CMD_EWP) ||
                       (cmd_r == `PFP_CMD_ERASE_WRITE_LOCK_CMD);
        dirty = |valid_r;
        // flush before a command or a word for another page
        need_flush = dirty && ((sel_r == `PFP_SEL_CMD) ||
                     (sel_r == `PFP_SEL_DATA && is_wr_cmd &&
                      addr_r[31:PAGE_BITS] != buf_page_r));
        ex = (st_r == pfp_pkg::ST_EXEC) && !need_flush;
        ex_data = ex && (sel_r == `PFP_SEL_DATA);
        buf_we = ex_data && is_wr_cmd;
        rd_go = ex_data && (cmd_r == `PFP_CMD_READ);
        ea_go = ex_data && (cmd_r == `PFP_CMD_EA) && lock_bits == '0;
        pg_erase = (st_r == pfp_pkg::ST_EXEC) && need_flush && is_erase_var;
        idx_last = (idx_r == '1);
        region = buf_page_r[REGION_PAGE_BITS +: LW];
    end

    // sequencing
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= pfp_pkg::ST_IDLE;
            ret_r <= pfp_pkg::ST_IDLE;
            idx_r <= '0;
        end else begin
            unique case (st_r)
                pfp_pkg::ST_IDLE: begin
                    if (!command_strobe_n) begin
                        st_r <= pfp_pkg::ST_EXEC;
                    end
                end
                pfp_pkg::ST_EXEC: begin
                    if (need_flush) begin
                        idx_r <= '0;
                        if (is_erase_var) begin
                            ret_r <= pfp_pkg::ST_FL_SCAN;
                            st_r <= pfp_pkg::ST_FLASH;
                        end else begin
                            st_r <= pfp_pkg::ST_FL_SCAN;
                        end
                    end else if (rd_go || ea_go) begin
                        ret_r <= rd_go ? pfp_pkg::ST_RD_OE
                                       : pfp_pkg::ST_WAIT_HI;
                        st_r <= pfp_pkg::ST_FLASH;
                    end else if (ex_data && cmd_r == `PFP_CMD_GLB) begin
                        st_r <= pfp_pkg::ST_RD_OE;
                    end else begin
                        st_r <= pfp_pkg::ST_WAIT_HI;
                    end
                end
                pfp_pkg::ST_FLASH: begin
                    if (fl_ack) begin
                        st_r <= ret_r;
                    end
                end
                pfp_pkg::ST_FL_SCAN: begin
                    // unwritten words are skipped, not programmed
                    st_r <= valid_r[idx_r] ? pfp_pkg::ST_FL_DATA
                                           : pfp_pkg::ST_FL_NEXT;
                end
                pfp_pkg::ST_FL_DATA: begin
                    ret_r <= pfp_pkg::ST_FL_NEXT;
                    st_r <= pfp_pkg::ST_FLASH;
                end
                pfp_pkg::ST_FL_NEXT: begin
                    idx_r <= idx_r + 1'b1;
                    st_r <= idx_last ? pfp_pkg::ST_FL_END
                                     : pfp_pkg::ST_FL_SCAN;
                end
                pfp_pkg::ST_FL_END: begin
                    // back to execute the access that forced the flush
                    st_r <= pfp_pkg::ST_EXEC;
                end
                pfp_pkg::ST_RD_OE: begin
                    if (!read_output_enable_n) begin
                        st_r <= pfp_pkg::ST_RD_VAL;
                    end
                end
                pfp_pkg::ST_RD_VAL: begin
                    st_r <= pfp_pkg::ST_RD_HOLD;
                end
                pfp_pkg::ST_RD_HOLD: begin
                    if (read_output_enable_n) begin
                        st_r <= pfp_pkg::ST_RD_REL;
                    end
                end
                pfp_pkg::ST_RD_REL: begin
                    st_r <= pfp_pkg::ST_WAIT_HI;
                end
                pfp_pkg::ST_WAIT_HI: begin
                    if (command_strobe_n) begin
                        st_r <= pfp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_r <= pfp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // capture of select field and data
    always_ff @(posedge mclk) begin
        if (srst) begin
            sel_r <= 4'hF;
            data_r <= 16'h0000;
        end else if (st_r == pfp_pkg::ST_IDLE && !command_strobe_n) begin
            sel_r <= sel_s;
            data_r <= data_s;
        end
    end

    // handshake pins
    always_ff @(posedge mclk) begin
        if (srst) begin
            device_ready_pin <= `PFP_RST_PIN;
            data_drive_flag_n_pin <= `PFP_RST_PIN;
            bidir_data_bus_oe <= 1'b0;
            bidir_data_bus_out <= 16'h0000;
        end else begin
            if (st_r == pfp_pkg::ST_IDLE && !command_strobe_n) begin
                device_ready_pin <= 1'b0;
            end else if (st_r == pfp_pkg::ST_WAIT_HI && command_strobe_n) begin
                device_ready_pin <= 1'b1;
            end
            if (st_r == pfp_pkg::ST_RD_OE && !read_output_enable_n) begin
                bidir_data_bus_oe <= 1'b1;
                bidir_data_bus_out <= rword_r;
            end else if (st_r == pfp_pkg::ST_RD_HOLD && read_output_enable_n) begin
                bidir_data_bus_oe <= 1'b0;
            end
            // flag follows the drive by one cycle each way
            if (st_r == pfp_pkg::ST_RD_VAL) begin
                data_drive_flag_n_pin <= 1'b0;
            end else if (st_r == pfp_pkg::ST_RD_REL) begin
                data_drive_flag_n_pin <= 1'b1;
            end
        end
    end

    // flash requests and returned word
    always_ff @(posedge mclk) begin
        if (srst) begin
            fl_req <= 1'b0;
            fl_op <= `PFP_FL_READ;
            fl_addr <= `PFP_RST_ADDR;
            fl_wdata <= 16'h0000;
            rword_r <= 16'h0000;
        end else begin
            if (st_r == pfp_pkg::ST_FLASH && fl_ack) begin
                fl_req <= 1'b0;
                if (fl_op == `PFP_FL_READ) begin
                    rword_r <= fl_rdata;
                end
            end else if (rd_go) begin
                fl_req <= 1'b1;
                fl_op <= `PFP_FL_READ;
                fl_addr <= addr_r;
            end else if (ea_go) begin
                fl_req <= 1'b1;
                fl_op <= `PFP_FL_ERASE_ALL;
            end else if (pg_erase) begin
                fl_req <= 1'b1;
                fl_op <= `PFP_FL_ERASE_PAGE;
                fl_addr <= {buf_page_r, {PAGE_BITS{1'b0}}};
            end else if (st_r == pfp_pkg::ST_FL_DATA) begin
                fl_req <= 1'b1;
                fl_op <= `PFP_FL_PROG;
                fl_addr <= {buf_page_r, idx_r};
                fl_wdata <= buf_rdata;
            end
            if (ex_data && cmd_r == `PFP_CMD_GLB) begin
                rword_r <= 16'(lock_bits);
            end
        end
    end

    // command and address words
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_r <= `PFP_RST_CMD;
            addr_r <= `PFP_RST_ADDR;
        end else if (ex) begin
            if (sel_r == `PFP_SEL_CMD) begin
                cmd_r <= data_r;
            end else if (sel_r == `PFP_SEL_ADDR_LO) begin
                addr_r[15:0] <= data_r;
            end else if (sel_r == `PFP_SEL_ADDR_HI) begin
                addr_r[31:16] <= data_r;
            end else if (buf_we || rd_go) begin
                addr_r <= addr_r + 32'h0000_0001;
            end
        end
    end

    // load buffer occupancy
    always_ff @(posedge mclk) begin
        if (srst) begin
            valid_r <= '0;
            buf_page_r <= '0;
        end else if (st_r == pfp_pkg::ST_FL_END) begin
            valid_r <= '0;
        end else if (buf_we) begin
            valid_r[addr_r[PAGE_BITS-1:0]] <= 1'b1;
            buf_page_r <= addr_r[31:PAGE_BITS];
        end
    end

    // lock bits
    always_ff @(posedge mclk) begin
        if (srst) begin
            lock_bits <= '0;
        end else if (st_r == pfp_pkg::ST_FL_END && is_lock_var) begin
            lock_bits[region] <= 1'b1;
        end else if (ex_data && cmd_r == `PFP_CMD_SLB) begin
            lock_bits <= lock_bits | data_r[NLOCK-1:0];
        end else if (ex_data && cmd_r == `PFP_CMD_CLB) begin
            lock_bits <= lock_bits & ~data_r[NLOCK-1:0];
        end
    end

    AST_READY_DROPS: assert property (@(posedge mclk) disable iff (srst)
        (st_r == pfp_pkg::ST_IDLE && !command_strobe_n) |=> !device_ready_pin)
        else $error("ready did not drop after capture");
    AST_CAPTURE: assert property (@(posedge mclk) disable iff (srst)
        (st_r == pfp_pkg::ST_IDLE && !command_strobe_n)
        |=> sel_r == $past(sel_s) && data_r == $past(data_s))
        else $error("select or data not captured");
    AST_READY_RISE: assert property (@(posedge mclk) disable iff (srst)
        $rose(device_ready_pin) |-> $past(command_strobe_n)
        && $past(st_r) == pfp_pkg::ST_WAIT_HI)
        else $error("ready rose without strobe high");
    AST_DRIVE_ON_OE: assert property (@(posedge mclk) disable iff (srst)
        $rose(bidir_data_bus_oe) |-> $past(!read_output_enable_n)
        ##1 !data_drive_flag_n_pin)
        else $error("drive not followed by flag low");
    AST_RELEASE: assert property (@(posedge mclk) disable iff (srst)
        (st_r == pfp_pkg::ST_RD_HOLD && read_output_enable_n)
        |=> !bidir_data_bus_oe ##1 data_drive_flag_n_pin)
        else $error("bus not released after output enable high");
    AST_NO_DRIVE_READY: assert property (@(posedge mclk) disable iff (srst)
        device_ready_pin |-> !bidir_data_bus_oe && data_drive_flag_n_pin)
        else $error("bus driven while ready");
    AST_FLUSH_FIRST: assert property (@(posedge mclk) disable iff (srst)
        (st_r == pfp_pkg::ST_EXEC && sel_r == `PFP_SEL_CMD && dirty)
        |=> st_r != pfp_pkg::ST_WAIT_HI && cmd_r == $past(cmd_r))
        else $error("command taken before flush");
    AST_EA_LOCKED: assert property (@(posedge mclk) disable iff (srst)
        $rose(fl_req) && fl_op == `PFP_FL_ERASE_ALL |-> $past(lock_bits) == '0)
        else $error("full erase with locked region");
    AST_LOCK_SET: assert property (@(posedge mclk) disable iff (srst)
        (ex_data && cmd_r == `PFP_CMD_SLB)
        |=> lock_bits == ($past(lock_bits) | $past(data_r[NLOCK-1:0])))
        else $error("lock set mask not applied");
    AST_LOCK_CLR: assert property (@(posedge mclk) disable iff (srst)
        (ex_data && cmd_r == `PFP_CMD_CLB)
        |=> (lock_bits & $past(data_r[NLOCK-1:0])) == '0)
        else $error("lock clear mask not applied");
    AST_ERASE_BEFORE_PROG: assert property (@(posedge mclk) disable iff (srst)
        pg_erase |=> fl_req && fl_op == `PFP_FL_ERASE_PAGE)
        else $error("page erase not issued before programming");
endmodule

// ### core/pfp_params.svh
// constants of the parallel flash programming port
// assumes inclusion by bare name from the core files
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH

// register select field codes
`define PFP_SEL_CMD 4'h0
`define PFP_SEL_ADDR_LO 4'h1
`define PFP_SEL_ADDR_HI 4'h2
`define PFP_SEL_DATA 4'h5

// command codes
`define PFP_CMD_READ 16'h0011
`define PFP_CMD_WP 16'h0012
`define PFP_CMD_WPL 16'h0022
`define PFP_CMD_EWP 16'h0032
`define PFP_CMD_ERASE_WRITE_LOCK_CMD 16'h0042
`define PFP_CMD_EA 16'h0013
`define PFP_CMD_SLB 16'h0014
`define PFP_CMD_CLB 16'h0024
`define PFP_CMD_GLB 16'h0015

// flash request operation codes
`define PFP_FL_READ 2'h0
`define PFP_FL_PROG 2'h1
`define PFP_FL_ERASE_PAGE 2'h2
`define PFP_FL_ERASE_ALL 2'h3

// reset values
`define PFP_RST_CMD 16'h0000
`define PFP_RST_ADDR 32'h0000_0000
`define PFP_RST_PIN 1'h1

`endif

// ### core/pfp_pkg.sv
// types of the parallel flash programming port
// assumes nothing beyond a SystemVerilog compiler
package pfp_pkg;

    typedef enum logic [11:0] {
        ST_IDLE    = 12'h001,
        ST_EXEC    = 12'h002,
        ST_FLASH   = 12'h004,
        ST_FL_SCAN = 12'h008,
        ST_FL_DATA = 12'h010,
        ST_FL_NEXT = 12'h020,
        ST_FL_END  = 12'h040,
        ST_RD_OE   = 12'h080,
        ST_RD_VAL  = 12'h100,
        ST_RD_HOLD = 12'h200,
        ST_RD_REL  = 12'h400,
        ST_WAIT_HI = 12'h800
    } pfp_state_t;

endpackage

// ### core/pfp_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs idle high, as the pins are pulled up
`timescale 1ns/1ns
module pfp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pins and synchronised copy
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // reset to ones: pulled-up pins read high
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= '1;
            sync_out <= '1;
        end else begin
            meta_r <= pin_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ### core/pfp_page_buf.sv
// one-page load buffer with registered read data
// assumes a single writer and reader on mclk
`timescale 1ns/1ns
module pfp_page_buf #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // clock
    input wire logic mclk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_r
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        rdata_r <= mem_r[raddr];
    end
endmodule

// ### bench/pfp_flash_model.sv
// behavioural flash macro answering the port's request interface
// assumes one request outstanding, held until acknowledged
`timescale 1ns/1ns
`include "pfp_params.svh"
module pfp_flash_model #(
    parameter int PAGE_WORDS = 256
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // request side
    input wire logic fl_req,
    input wire logic [1:0] fl_op,
    input wire logic [31:0] fl_addr,
    input wire logic [15:0] fl_wdata,
    // answer side
    output logic fl_ack,
    output logic [15:0] fl_rdata
);
    logic [15:0] mem [int];
    int n_prog = 0;
    int n_erase = 0;
    int n_eall = 0;
    int wait_r;
    logic slow_r;

    // unwritten words read as erased
    function automatic logic [15:0] peek(input int a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    // every other request is slow, so both latencies are exercised;
    // outside the ack cycle the read data toggles, never holding stale
    always @(posedge mclk) begin
        if (srst) begin
            fl_ack <= 1'b0;
            fl_rdata <= 16'h0000;
            wait_r <= 0;
            slow_r <= 1'b0;
        end else if (fl_req && !fl_ack && wait_r < (slow_r ? 3 : 0)) begin
            wait_r <= wait_r + 1;
            fl_rdata <= ~fl_rdata;
        end else if (fl_req && !fl_ack) begin
            fl_ack <= 1'b1;
            wait_r <= 0;
            slow_r <= !slow_r;
            fl_rdata <= peek(int'(fl_addr));
            case (fl_op)
                `PFP_FL_PROG: begin
                    n_prog++;
                    mem[int'(fl_addr)] = fl_wdata;
                end
                `PFP_FL_ERASE_PAGE: begin
                    n_erase++;
                    for (int i = 0; i < PAGE_WORDS; i++) begin
                        mem.delete(int'(fl_addr) + i);
                    end
                end
                `PFP_FL_ERASE_ALL: begin
                    n_eall++;
                    mem.delete();
                end
                default: begin
                end
            endcase
        end else begin
            fl_ack <= 1'b0;
            fl_rdata <= ~fl_rdata;
        end
    end
endmodule

// ### bench/parallel_flash_programming_port_tb_top.sv
// self-checking bench: acts as the gang programmer on the pins
// assumes default port parameters: 256-word pages, 16 pages a region
`timescale 1ns/1ns
`include "pfp_params.svh"
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("CHECK FAILED %s exp %h got %h", nm, (e), (g)); \
    end \
end
module parallel_flash_programming_port_tb_top;
    logic mclk = 1'b0;
    logic srst;
    logic command_strobe_n;
    logic read_output_enable_n;
    logic [3:0] sel;
    logic [15:0] bus_in;
    logic [15:0] bus_out;
    logic bus_oe;
    logic ready;
    logic flag_n;
    logic fl_req;
    logic [1:0] fl_op;
    logic [31:0] fl_addr;
    logic [15:0] fl_wdata;
    logic fl_ack;
    logic [15:0] fl_rdata;
    logic [15:0] lock_bits;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    always #20 mclk = ~mclk;

    pfp_port DUT (.mclk(mclk), .srst(srst),
        .command_strobe_n_pin(command_strobe_n),
        .read_output_enable_n_pin(read_output_enable_n),
        .register_select_field(sel), .bidir_data_bus_in(bus_in),
        .bidir_data_bus_out(bus_out), .bidir_data_bus_oe(bus_oe),
        .device_ready_pin(ready), .data_drive_flag_n_pin(flag_n),
        .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
        .lock_bits(lock_bits));

    pfp_flash_model FL (.mclk(mclk), .srst(srst), .fl_req(fl_req),
        .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
        .fl_ack(fl_ack), .fl_rdata(fl_rdata));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a few hundred handshakes at most; far below this ceiling
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    // released lines float to the pull-up level
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        step();
        sel = s;
        bus_in = d;
        command_strobe_n = 1'b0;
        while (ready !== 1'b0) step();
        sel = 4'hF;
        bus_in = 16'hFFFF;
        repeat (3) step();
        `CHK("ready held low", 1'b0, ready)
        command_strobe_n = 1'b1;
        while (ready !== 1'b1) step();
    endtask

    task automatic rd(input logic [15:0] exp, input string what);
        step();
        sel = `PFP_SEL_DATA;
        command_strobe_n = 1'b0;
        while (ready !== 1'b0) step();
        sel = 4'hF;
        step();
        read_output_enable_n = 1'b0;
        while (flag_n !== 1'b0) step();
        `CHK("bus driven", 1'b1, bus_oe)
        `CHK(what, exp, bus_out)
        read_output_enable_n = 1'b1;
        while (flag_n !== 1'b1) step();
        `CHK("bus released", 1'b0, bus_oe)
        `CHK("ready before strobe", 1'b0, ready)
        command_strobe_n = 1'b1;
        while (ready !== 1'b1) step();
    endtask

    task automatic addr(input logic [15:0] lo);
        wr(`PFP_SEL_ADDR_LO, lo);
        wr(`PFP_SEL_ADDR_HI, 16'h0000);
    endtask

    task automatic t_reset();
        `CHK("ready", 1'b1, ready)
        `CHK("flag", 1'b1, flag_n)
        `CHK("oe", 1'b0, bus_oe)
        `CHK("locks", 16'h0000, lock_bits)
    endtask

    task automatic t_write_read();
        wr(`PFP_SEL_CMD, `PFP_CMD_WP);
        addr(16'h0010);
        wr(`PFP_SEL_DATA, 16'hA5C3);
        wr(`PFP_SEL_DATA, 16'h5A3C);
        wr(`PFP_SEL_DATA, 16'h0F0F);
        `CHK("buffered only", 0, FL.n_prog)
        wr(`PFP_SEL_CMD, `PFP_CMD_READ);
        `CHK("words flushed", 3, FL.n_prog)
        `CHK("flash word", 16'h5A3C, FL.peek(17))
        addr(16'h0010);
        rd(16'hA5C3, "read 0");
        rd(16'h5A3C, "read 1");
        rd(16'h0F0F, "read 2");
        addr(16'h0011);
        rd(16'h5A3C, "reread");
        // a nonzero high word must move the read off the written page
        wr(`PFP_SEL_ADDR_HI, 16'h0001);
        rd(16'hFFFF, "high word");
    endtask

    task automatic t_page_change();
        wr(`PFP_SEL_CMD, `PFP_CMD_WP);
        addr(16'h00FF);
        wr(`PFP_SEL_DATA, 16'h1111);
        wr(`PFP_SEL_DATA, 16'h2222);
        `CHK("page flushed", 4, FL.n_prog)
        `CHK("old page word", 16'h1111, FL.peek(255))
        wr(`PFP_SEL_CMD, `PFP_CMD_READ);
        `CHK("new page word", 16'h2222, FL.peek(256))
    endtask

    task automatic t_erase_write();
        wr(`PFP_SEL_CMD, `PFP_CMD_WP);
        addr(16'h0201);
        wr(`PFP_SEL_DATA, 16'h1234);
        wr(`PFP_SEL_CMD, `PFP_CMD_EWP);
        addr(16'h0200);
        wr(`PFP_SEL_DATA, 16'hBEEF);
        wr(`PFP_SEL_CMD, `PFP_CMD_READ);
        `CHK("page erases", 1, FL.n_erase)
        `CHK("erased word", 16'hFFFF, FL.peek(513))
        `CHK("programmed", 16'hBEEF, FL.peek(512))
    endtask

    task automatic t_locks();
        wr(`PFP_SEL_CMD, `PFP_CMD_WPL);
        addr(16'h1000);
        wr(`PFP_SEL_DATA, 16'h0001);
        wr(`PFP_SEL_CMD, `PFP_CMD_GLB);
        rd(16'h0002, "lock mask");
        wr(`PFP_SEL_CMD, `PFP_CMD_ERASE_WRITE_LOCK_CMD);
        addr(16'h2000);
        wr(`PFP_SEL_DATA, 16'h0002);
        wr(`PFP_SEL_CMD, `PFP_CMD_EA);
        wr(`PFP_SEL_DATA, 16'h0000);
        `CHK("erase-lock", 16'h0006, lock_bits)
        `CHK("erase of page", 2, FL.n_erase)
        `CHK("erase aborted", 0, FL.n_eall)
        wr(`PFP_SEL_CMD, `PFP_CMD_SLB);
        wr(`PFP_SEL_DATA, 16'h8001);
        `CHK("set mask", 16'h8007, lock_bits)
        wr(`PFP_SEL_CMD, `PFP_CMD_CLB);
        wr(`PFP_SEL_DATA, 16'h8005);
        `CHK("clear mask", 16'h0002, lock_bits)
        wr(`PFP_SEL_CMD, `PFP_CMD_CLB);
        wr(`PFP_SEL_DATA, 16'hFFFF);
        wr(`PFP_SEL_CMD, `PFP_CMD_EA);
        wr(`PFP_SEL_DATA, 16'h0000);
        `CHK("full erase", 1, FL.n_eall)
        `CHK("word erased", 16'hFFFF, FL.peek(16))
    endtask

    task automatic t_bad_select();
        wr(`PFP_SEL_CMD, `PFP_CMD_WP);
        addr(16'h0040);
        wr(`PFP_SEL_DATA, 16'h7777);
        wr(4'h3, `PFP_CMD_READ);
        wr(4'h4, `PFP_CMD_READ);
        `CHK("no command", 9, FL.n_prog)
        wr(`PFP_SEL_CMD, `PFP_CMD_READ);
        `CHK("flushed", 16'h7777, FL.peek(64))
    endtask

    initial begin
        srst = 1'b1;
        command_strobe_n = 1'b1;
        read_output_enable_n = 1'b1;
        sel = 4'hF;
        bus_in = 16'hFFFF;
        // no handshake until the power-on reset period is over
        repeat (8) @(posedge mclk);
        #1;
        srst = 1'b0;
        step();
        t_reset();
        t_write_read();
        t_page_change();
        t_erase_write();
        t_locks();
        t_bad_select();
        results();
    end
endmodule
